//--- xcrc_consts.svh
`ifndef XCRC_CONSTS_SVH
`define XCRC_CONSTS_SVH
`define XCRC_LANES      2
`define XCRC_DQ_W       8
`define XCRC_LANE_W     9
`define XCRC_MASK_BIT   8
`define XCRC_BEATS      10
`define XCRC_BEAT_CNT_W 4
`define XCRC_LAST_BEAT  4'h9
`define XCRC_CRC_BEAT   8
`define XCRC_HALF_BEATS 4
`define XCRC_HALF_SHIFT 4
`define XCRC_TREE_W     36
`define XCRC_MASK_POS   32
`define XCRC_SYNC_W     3
`endif

//--- xcrc_pkg.sv
package xcrc_pkg;
   // One beat of the link: per lane, bits 7:0 are the data lines, bit 8 the mask lane.
   typedef logic [1:0][8:0] xcrc_beat_t;
   typedef struct packed
   {
      logic                  halfSel;
      logic                  chopped;
      logic [9:0][1:0][8:0]  beat;
   } xcrc_raw_t;
   typedef struct packed
   {
      logic [1:0][35:0] treeIn;
      logic [1:0][7:0]  crcRx;
      logic             formatErr;
   } xcrc_tree_t;
endpackage : xcrc_pkg

//--- xcrc_tree_map.sv
`timescale 1ns/1ns
`include "xcrc_consts.svh"
module xcrc_tree_map
#(
   parameter int BUF_DEPTH = 2
)
(
   // Core clock and reset.
   input  wire logic               ref_clk,
   input  wire logic               reset,
   // Link side, on the strobe clock.
   input  wire logic               strobeClk,
   input  wire logic               beatValid,
   input  wire logic [7:0]         dqLower,
   input  wire logic               maskLaneLower,
   input  wire logic [7:0]         dqUpper,
   input  wire logic               maskLaneUpper,
   input  wire logic               burstChopHalfSelect,
   input  wire logic               burstChopped,
   output logic                    linkBusy,
   // Mode controls, core domain.
   input  wire logic               dataMaskEnable,
   input  wire logic               dataBusInversionEnable,
   // Tree input stream, core domain.
   output logic                    treeValid,
   input  wire logic               treeReady,
   output xcrc_pkg::xcrc_tree_t    treeWord,
   output logic                    overrunPulse
);

   localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

   // The buffer pointers wrap by overflow, and the tree layout below relies on
   // the package types and the constants agreeing on every width.
   if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("BUF_DEPTH must be a power of two and at least 2");
   end
   if (`XCRC_TREE_W != `XCRC_DQ_W * `XCRC_HALF_BEATS + `XCRC_HALF_BEATS)
   begin : g_bad_tree
      $error("Each tree must take eight lines of four beats plus four mask bits");
   end
   if (`XCRC_MASK_POS != `XCRC_DQ_W * `XCRC_HALF_BEATS)
   begin : g_bad_mask
      $error("Mask positions must follow the data positions");
   end
   if ($bits(xcrc_pkg::xcrc_beat_t) != `XCRC_LANES * `XCRC_LANE_W)
   begin : g_bad_beat
      $error("Beat type does not match the lane count and width");
   end
   if ($bits(xcrc_pkg::xcrc_raw_t) != `XCRC_BEATS * `XCRC_LANES * `XCRC_LANE_W + 2)
   begin : g_bad_raw
      $error("Burst type does not hold ten beats");
   end
   if ($bits(xcrc_pkg::xcrc_tree_t) != `XCRC_LANES * (`XCRC_TREE_W + `XCRC_DQ_W) + 1)
   begin : g_bad_word
      $error("Tree word type does not match the tree and lane widths");
   end

   // Link domain: collect ten beats of a write burst.
   logic [`XCRC_BEAT_CNT_W-1:0] beatCount_reg;
   xcrc_pkg::xcrc_raw_t         capture_reg;
   xcrc_pkg::xcrc_raw_t         hold_reg;
   logic                        reqToggle_reg;
   logic                        ovrToggle_reg;
   logic [`XCRC_SYNC_W-1:0]     ackSync_reg;
   logic                        ackStable_reg;

   // Lane 0 is the lower byte lane; bit 8 of each lane carries its mask line.
   wire xcrc_pkg::xcrc_beat_t curBeat  = {maskLaneUpper, dqUpper, maskLaneLower, dqLower};
   wire                       lastBeat = beatValid && (beatCount_reg == `XCRC_LAST_BEAT);
   wire                       busy     = reqToggle_reg != ackStable_reg;
   wire                       firstBeat = beatValid && (beatCount_reg == 4'h0);
   wire                       loadHold = lastBeat && !busy;
   wire                       dropBurst = lastBeat && busy;
   wire [`XCRC_BEAT_CNT_W-1:0] beatCount_next =
      lastBeat ? 4'h0 : (beatValid ? beatCount_reg + 4'h1 : beatCount_reg);
   wire                       ackAgree = ackSync_reg[1] == ackSync_reg[2];

   assign linkBusy = busy;

   always_ff @(posedge strobeClk or posedge reset)
   begin
      if (reset)
      begin
         beatCount_reg <= 4'h0;
         capture_reg   <= '0;
      end
      else
      begin
         beatCount_reg <= beatCount_next;
         if (beatValid)
         begin
            capture_reg.beat[beatCount_reg] <= curBeat;
         end
         if (firstBeat)
         begin
            capture_reg.halfSel <= burstChopHalfSelect;
            capture_reg.chopped <= burstChopped;
         end
      end
   end

   // The hold register stays still from request to acknowledge, so the core may
   // sample it freely; a burst that ends while it is still owned is dropped.
   always_ff @(posedge strobeClk or posedge reset)
   begin
      if (reset)
      begin
         hold_reg      <= '0;
         reqToggle_reg <= 1'b0;
         ovrToggle_reg <= 1'b0;
      end
      else
      begin
         if (loadHold)
         begin
            hold_reg.halfSel <= capture_reg.halfSel;
            hold_reg.chopped <= capture_reg.chopped;
            hold_reg.beat    <= {curBeat, capture_reg.beat[8:0]};
            reqToggle_reg    <= ~reqToggle_reg;
         end
         if (dropBurst)
         begin
            ovrToggle_reg <= ~ovrToggle_reg;
         end
      end
   end

   logic ackToggle_reg;

   // The acknowledge only advances on strobe edges, so after the last burst the
   // link reads busy until the next burst brings its clock back.

   always_ff @(posedge strobeClk or posedge reset)
   begin
      if (reset)
      begin
         ackSync_reg   <= '0;
         ackStable_reg <= 1'b0;
      end
      else
      begin
         ackSync_reg <= {ackSync_reg[1:0], ackToggle_reg};
         if (ackAgree)
         begin
            ackStable_reg <= ackSync_reg[2];
         end
      end
   end

   // Core domain: take requests and overrun events across.
   logic [`XCRC_SYNC_W-1:0] reqSync_reg;
   logic                    reqStable_reg;
   logic [`XCRC_SYNC_W-1:0] ovrSync_reg;
   logic                    ovrStable_reg;

   wire reqAgree = reqSync_reg[1] == reqSync_reg[2];
   wire ovrAgree = ovrSync_reg[1] == ovrSync_reg[2];
   wire ovrEvent = ovrAgree && (ovrSync_reg[2] != ovrStable_reg);

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         reqSync_reg   <= '0;
         reqStable_reg <= 1'b0;
      end
      else
      begin
         reqSync_reg <= {reqSync_reg[1:0], reqToggle_reg};
         if (reqAgree)
         begin
            reqStable_reg <= reqSync_reg[2];
         end
      end
   end

   // The overrun toggle is counted once, when two stages agree on its new level.
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         ovrSync_reg   <= '0;
         ovrStable_reg <= 1'b0;
         overrunPulse  <= 1'b0;
      end
      else
      begin
         ovrSync_reg  <= {ovrSync_reg[1:0], ovrToggle_reg};
         overrunPulse <= ovrEvent;
         if (ovrAgree)
         begin
            ovrStable_reg <= ovrSync_reg[2];
         end
      end
   end

   // Map the held burst onto the two trees.
   xcrc_pkg::xcrc_tree_t mapped;
   wire maskFnOn = dataMaskEnable || dataBusInversionEnable;
   // With the half select high, beats 4 to 7 take the place of beats 0 to 3.
   wire [3:0] halfBase = hold_reg.halfSel ? 4'(`XCRC_HALF_SHIFT) : 4'h0;

   logic [1:0] laneErr;

   genvar lane, bitIdx, beatIdx;
   generate
      for (lane = 0; lane < `XCRC_LANES; lane++)
      begin : g_lane
         // Each tree sees 8 lines x 4 beats of data plus 4 mask-lane beats.
         for (bitIdx = 0; bitIdx < `XCRC_DQ_W; bitIdx++)
         begin : g_bit
            for (beatIdx = 0; beatIdx < `XCRC_HALF_BEATS; beatIdx++)
            begin : g_beat
               assign mapped.treeIn[lane][bitIdx*4+beatIdx] =
                  hold_reg.beat[halfBase + 4'(beatIdx)][lane][bitIdx];
            end
            assign mapped.crcRx[lane][bitIdx] = hold_reg.beat[`XCRC_CRC_BEAT][lane][bitIdx];
         end
         for (beatIdx = 0; beatIdx < `XCRC_HALF_BEATS; beatIdx++)
         begin : g_mask
            // Both functions off: the mask positions are fixed ones.
            assign mapped.treeIn[lane][`XCRC_MASK_POS+beatIdx] = !maskFnOn ||
               hold_reg.beat[halfBase + 4'(beatIdx)][lane][`XCRC_MASK_BIT];
         end
         // A chopped burst must pad beats 4-7 and 9, and the mask lane at beat 8.
         assign laneErr[lane] = !(&{hold_reg.beat[7][lane], hold_reg.beat[6][lane],
                                    hold_reg.beat[5][lane], hold_reg.beat[4][lane],
                                    hold_reg.beat[9][lane],
                                    hold_reg.beat[`XCRC_CRC_BEAT][lane][`XCRC_MASK_BIT]});
      end
   endgenerate

   assign mapped.formatErr = hold_reg.chopped && (|laneErr);

   // Output buffer; a stalled receiver holds the acknowledge back, which keeps
   // the link busy so later bursts are reported as overruns, never overwritten.
   xcrc_pkg::xcrc_tree_t mem_reg [BUF_DEPTH];
   logic [PTR_W-1:0]     wrPtr_reg;
   logic [PTR_W-1:0]     rdPtr_reg;
   logic [PTR_W:0]       fill_reg;

   // A word is pending from the synced request until the push answers it.
   wire pending  = reqStable_reg != ackToggle_reg;
   wire bufReady = fill_reg != (PTR_W+1)'(BUF_DEPTH);
   wire push     = pending && bufReady;
   wire pop      = treeValid && treeReady;
   wire [PTR_W:0] fill_next = fill_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

   assign treeValid = fill_reg != '0;
   assign treeWord  = mem_reg[rdPtr_reg];

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         wrPtr_reg     <= '0;
         rdPtr_reg     <= '0;
         fill_reg      <= '0;
         ackToggle_reg <= 1'b0;
      end
      else
      begin
         fill_reg <= fill_next;
         if (push)
         begin
            wrPtr_reg     <= wrPtr_reg + PTR_W'(1);
            ackToggle_reg <= ~ackToggle_reg;
         end
         if (pop)
         begin
            rdPtr_reg <= rdPtr_reg + PTR_W'(1);
         end
      end
   end

   // One row of flops per buffer entry; only the addressed row loads.
   genvar entry;
   generate
      for (entry = 0; entry < BUF_DEPTH; entry++)
      begin : g_entry
         wire rowLoad = push && (wrPtr_reg == PTR_W'(entry));

         always_ff @(posedge ref_clk or posedge reset)
         begin
            if (reset)
            begin
               mem_reg[entry] <= '0;
            end
            else if (rowLoad)
            begin
               mem_reg[entry] <= mapped;
            end
         end
      end
   endgenerate

endmodule : xcrc_tree_map

//--- xcrc_tree_map_assertions.sv
`timescale 1ns/1ns
module xcrc_tree_map_assertions
#(
   parameter int BUF_DEPTH = 2
)
(
   // Core side.
   input wire logic                 ref_clk,
   input wire logic                 reset,
   input wire logic                 dataMaskEnable,
   input wire logic                 dataBusInversionEnable,
   input wire logic                 treeValid,
   input wire logic                 treeReady,
   input wire xcrc_pkg::xcrc_tree_t treeWord,
   input wire logic                 overrunPulse,
   // Link side.
   input wire logic                 strobeClk,
   input wire logic                 beatValid,
   input wire logic                 linkBusy
);
   word_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      treeValid && !treeReady |=> treeValid && $stable(treeWord))
      else $error("Word moved while stalled.");
   valid_drop_a: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(treeValid) |-> $past(treeReady)) else $error("Word lost without pop.");
   // Enables must also be low a cycle earlier, since they are sampled at push time.
   lower_fill_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(treeValid) && !(dataMaskEnable | dataBusInversionEnable)
      && $past(!(dataMaskEnable | dataBusInversionEnable)) |-> treeWord.treeIn[0][35:32] == 4'hF)
      else $error("Lower mask inputs not ones.");
   upper_fill_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(treeValid) && !(dataMaskEnable | dataBusInversionEnable)
      && $past(!(dataMaskEnable | dataBusInversionEnable)) |-> treeWord.treeIn[1][35:32] == 4'hF)
      else $error("Upper mask inputs not ones.");
   busy_start_a: assert property (@(posedge strobeClk) disable iff (reset)
      $rose(linkBusy) |-> $past(beatValid)) else $error("Busy without a beat.");
   busy_hold_a: assert property (@(posedge strobeClk) disable iff (reset)
      $rose(linkBusy) |-> linkBusy [*3]) else $error("Busy released too early.");
   overrun_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
      overrunPulse |=> !overrunPulse) else $error("Overrun pulse too long.");
endmodule : xcrc_tree_map_assertions

//--- xcrc_ctrl_model.sv
`timescale 1ns/1ns
module xcrc_ctrl_model
(
   // Link lines, changed on the falling strobe edge.
   output logic                 strobeClk,
   output logic                 beatValid,
   output logic                 halfSel,
   output logic                 chopped,
   output xcrc_pkg::xcrc_beat_t beat
);
   initial
   begin
      strobeClk = 1'b0;
      beatValid = 1'b0;
      halfSel   = 1'b0;
      chopped   = 1'b0;
      beat      = '1;
   end
   // The clock stands still between bursts, and released lines show the inverse of
   // the last beat so that a stale sample cannot pass by luck.
   task automatic send(input xcrc_pkg::xcrc_raw_t r);
      // Start off the core clock grid so that no strobe edge falls on a core clock edge.
      #7;
      for (int b = 0; b < 10; b++)
      begin
         #80 strobeClk = 1'b0;
         beatValid = 1'b1;
         halfSel   = r.halfSel;
         chopped   = r.chopped;
         beat      = r.beat[b];
         #80 strobeClk = 1'b1;
      end
      #80 strobeClk = 1'b0;
      beatValid = 1'b0;
      beat      = ~beat;
   endtask : send
endmodule : xcrc_ctrl_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic                 ref_clk, reset, treeReady, maskOn, invOn;
   logic                 strobeClk, beatValid, halfSel, chopped;
   logic                 linkBusy, treeValid, overrunPulse;
   xcrc_pkg::xcrc_beat_t beat;
   xcrc_pkg::xcrc_tree_t treeWord;
   int                   err_total = 0, compares = 0, overruns = 0;
   xcrc_ctrl_model ctrl_u (.strobeClk(strobeClk), .beatValid(beatValid), .halfSel(halfSel),
      .chopped(chopped), .beat(beat));
   xcrc_tree_map #(.BUF_DEPTH(2)) dut_u (.ref_clk(ref_clk), .reset(reset),
      .strobeClk(strobeClk), .beatValid(beatValid), .dqLower(beat[0][7:0]),
      .maskLaneLower(beat[0][8]), .dqUpper(beat[1][7:0]), .maskLaneUpper(beat[1][8]),
      .burstChopHalfSelect(halfSel), .burstChopped(chopped), .linkBusy(linkBusy),
      .dataMaskEnable(maskOn), .dataBusInversionEnable(invOn), .treeValid(treeValid),
      .treeReady(treeReady), .treeWord(treeWord), .overrunPulse(overrunPulse));
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (overrunPulse === 1'b1)
         overruns++;
   function automatic xcrc_pkg::xcrc_raw_t make_raw(input logic h, input logic c, input int k);
      xcrc_pkg::xcrc_raw_t r;
      r.halfSel = h;
      r.chopped = c;
      for (int b = 0; b < 10; b++)
         r.beat[b] = 18'(18'h2C9B5 * (b + 1) + 18'h1357 * k);
      if (c)
      begin
         r.beat[7:4] = '1;
         r.beat[9] = '1;
         r.beat[8][0][8] = 1'b1;
         r.beat[8][1][8] = 1'b1;
      end
      return r;
   endfunction : make_raw
   function automatic xcrc_pkg::xcrc_tree_t expect_word(input xcrc_pkg::xcrc_raw_t r);
      xcrc_pkg::xcrc_tree_t w;
      int s;
      s = r.halfSel ? 4 : 0;
      for (int l = 0; l < 2; l++)
      begin
         for (int j = 0; j < 4; j++)
         begin
            for (int i = 0; i < 8; i++)
               w.treeIn[l][i * 4 + j] = r.beat[j + s][l][i];
            w.treeIn[l][32 + j] = r.beat[j + s][l][8] | !(maskOn | invOn);
         end
         w.crcRx[l] = r.beat[8][l][7:0];
      end
      w.formatErr = r.chopped && !(&r.beat[7:4] && &r.beat[9] && r.beat[8][0][8] && r.beat[8][1][8]);
      return w;
   endfunction : expect_word
   task automatic check(input logic [88:0] got, input logic [88:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic pop_check(input xcrc_pkg::xcrc_tree_t e);
      @(negedge ref_clk);
      for (int n = 0; n < 60 && treeValid !== 1'b1; n++)
         @(negedge ref_clk);
      check(89'(treeValid), 89'h1);
      check(treeWord, e);
      treeReady = 1'b1;
      @(negedge ref_clk);
      treeReady = 1'b0;
   endtask : pop_check
   task automatic test_modes();
      xcrc_pkg::xcrc_raw_t r;
      for (int m = 0; m < 8; m++)
      begin
         {maskOn, invOn} = 2'(m);
         r = make_raw(m[2], 1'b0, m);
         ctrl_u.send(r);
         pop_check(expect_word(r));
      end
   endtask : test_modes
   task automatic test_chop();
      xcrc_pkg::xcrc_raw_t r;
      {maskOn, invOn} = 2'h2;
      for (int k = 0; k < 2; k++)
      begin
         r = make_raw(1'(k), 1'b1, 20 + k);
         r.beat[5][1][3] = 1'(k == 0);
         ctrl_u.send(r);
         pop_check(expect_word(r));
      end
   endtask : test_chop
   task automatic test_buffer();
      xcrc_pkg::xcrc_raw_t r[4];
      for (int k = 0; k < 4; k++)
      begin
         r[k] = make_raw(1'b0, 1'b0, 40 + k);
         ctrl_u.send(r[k]);
      end
      check(89'(linkBusy), 89'h1);
      for (int k = 0; k < 3; k++)
         pop_check(expect_word(r[k]));
      repeat (20) @(negedge ref_clk);
      check(89'(overruns), 89'h1);
      check(89'(treeValid), 89'h0);
   endtask : test_buffer
   task automatic test_reset();
      xcrc_pkg::xcrc_raw_t r;
      @(negedge ref_clk);
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      check(89'({linkBusy, treeValid, overrunPulse}), 89'h0);
      check(treeWord, 89'h0);
      reset = 1'b0;
      r = make_raw(1'b1, 1'b0, 60);
      ctrl_u.send(r);
      pop_check(expect_word(r));
   endtask : test_reset
   task automatic print_verdict();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial
   begin
      reset = 1'b1;
      treeReady = 1'b0;
      {maskOn, invOn} = 2'h0;
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      test_modes();
      test_chop();
      test_buffer();
      test_reset();
      print_verdict();
   end
   initial
   begin
      #200000 err_total++;
      print_verdict();
   end
endmodule : tb_top
bind xcrc_tree_map xcrc_tree_map_assertions #(.BUF_DEPTH(BUF_DEPTH)) chk_u (.ref_clk(ref_clk),
   .reset(reset), .dataMaskEnable(dataMaskEnable), .dataBusInversionEnable(dataBusInversionEnable),
   .treeValid(treeValid), .treeReady(treeReady), .treeWord(treeWord), .overrunPulse(overrunPulse),
   .strobeClk(strobeClk), .beatValid(beatValid), .linkBusy(linkBusy));
